/* logic/smrw_ctrl.sv */
// Controller that loads and reads DRAM pattern registers
`timescale 1ns/10ps
`default_nettype none
module smrw_ctrl
    import smrw_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [2:0]  cmd_o,
    output logic      [1:0]  ba_o,
    output logic      [17:0] addr_o,
    output logic             dbi_en_o,
    input  wire logic [7:0]  dq_i,
    input  wire logic        dq_valid_i
);
    // ******************************************************************
    // Types and state
    // ******************************************************************
    typedef enum logic [2:0] {
        SMRW_IDLE, SMRW_PRE_WAIT, SMRW_MOD_WAIT, SMRW_RD_WAIT, SMRW_WR_WAIT,
        SMRW_EXIT_WAIT
    } smrw_state_t;

    smrw_state_t  state_ff;
    logic [5:0]   ctrl_ff;
    logic [5:0]   cnt_ff;
    logic         mode_ff;
    logic         busy_ff;
    logic         err_ff;
    logic         done_ff;
    logic [1:0]   loc_ff;
    logic [2:0]   op_ff;
    logic [7:0]   wdata_ff;
    logic [7:0]   rdata_ff;
    logic [2:0]   ui_ff;
    logic         ack_ff;
    logic [31:0]  rd_ff;
    logic [7:0]   dq_s1_ff;
    logic [7:0]   dq_s2_ff;
    logic         dv_s1_ff;
    logic         dv_s2_ff;
    logic         cmd_take;
    logic         refuse;
    logic [1:0]   fmt;

    assign fmt      = ctrl_ff[SMRW_CTRL_FMT_LSB +: 2];
    assign cmd_take = avs_write && ack_ff && avs_address == SMRW_OFF_CMD && !busy_ff;

    // Orders that break the device's read or write constraints are refused
    function automatic logic smrw_illegal(input logic [2:0] op, input logic [1:0] loc,
                                          input logic [1:0] f, input logic [1:0] pg,
                                          input logic md);
        smrw_illegal = 1'b0;
        if ((op == SMRW_OP_READ || op == SMRW_OP_WRITE) && !md)
            smrw_illegal = 1'b1;
        if (op == SMRW_OP_READ && f == SMRW_FMT_PARALLEL && loc != 2'h0)
            smrw_illegal = 1'b1;
        if (op == SMRW_OP_WRITE && pg != SMRW_PAGE0)
            smrw_illegal = 1'b1;
        if ((op == SMRW_OP_READ || op == SMRW_OP_ENTER) && f == 2'h3)
            smrw_illegal = 1'b1;
    endfunction : smrw_illegal

    assign refuse = smrw_illegal(avs_writedata[SMRW_CMD_OP_LSB +: 3],
                                 avs_writedata[SMRW_CMD_LOC_LSB +: 2], fmt,
                                 ctrl_ff[SMRW_CTRL_PAGE_LSB +: 2], mode_ff);

    // ******************************************************************
    // Avalon slave: one wait cycle, then ack
    // ******************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    // Waitrequest high until the ack cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
        end
    end

    // Read data mux, registered
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else begin
            unique case (avs_address)
                SMRW_OFF_CTRL:   avs_readdata <= {26'h0, ctrl_ff};
                SMRW_OFF_STATUS: avs_readdata <= {28'h0, done_ff, err_ff, mode_ff, busy_ff};
                SMRW_OFF_RDATA:  avs_readdata <= rd_ff;
                default:         avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_ff <= SMRW_CTRL_RST;
        end else if (avs_write && ack_ff && avs_address == SMRW_OFF_CTRL) begin
            ctrl_ff <= avs_writedata[5:0];
        end
    end

    // Error flag: set on refused order, cleared by a legal one
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            err_ff <= 1'b0;
        end else if (cmd_take) begin
            err_ff <= refuse;
        end
    end

    // ******************************************************************
    // Pin synchronisers for returned read data
    // ******************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            dq_s1_ff <= 8'h00;
            dq_s2_ff <= 8'h00;
            dv_s1_ff <= 1'b0;
            dv_s2_ff <= 1'b0;
        end else begin
            dq_s1_ff <= dq_i;
            dq_s2_ff <= dq_s1_ff;
            dv_s1_ff <= dq_valid_i;
            dv_s2_ff <= dv_s1_ff;
        end
    end

    // Capture burst, one UI per valid beat; lane 0 keeps UI order
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
            ui_ff    <= 3'h0;
            rd_ff    <= 32'h0000_0000;
        end else if (state_ff != SMRW_RD_WAIT) begin
            ui_ff <= 3'h0;
        end else if (dv_s2_ff) begin
            rdata_ff[ui_ff] <= dq_s2_ff[0];
            ui_ff           <= ui_ff + 3'h1;
            // First beat carries the whole pattern across lanes in parallel
            if (ui_ff == 3'h0 && fmt == SMRW_FMT_PARALLEL)
                rd_ff[15:8] <= dq_s2_ff;
            if (ui_ff == 3'h7)
                rd_ff[7:0] <= {dq_s2_ff[0], rdata_ff[6:0]};
        end
    end

    // ******************************************************************
    // Command sequencer
    // ******************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_ff <= SMRW_IDLE;
            cnt_ff   <= 6'h00;
            mode_ff  <= 1'b0;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
            loc_ff   <= 2'h0;
            op_ff    <= 3'h0;
            wdata_ff <= 8'h00;
            cmd_o    <= SMRW_DCMD_NOP;
            ba_o     <= 2'h0;
            addr_o   <= 18'h0_0000;
            dbi_en_o <= 1'b0;
        end else begin
            cmd_o    <= SMRW_DCMD_NOP;
            dbi_en_o <= 1'b0;
            unique case (state_ff)
                SMRW_IDLE: begin
                    if (cmd_take && !refuse) begin
                        busy_ff  <= 1'b1;
                        done_ff  <= 1'b0;
                        op_ff    <= avs_writedata[SMRW_CMD_OP_LSB +: 3];
                        loc_ff   <= avs_writedata[SMRW_CMD_LOC_LSB +: 2];
                        wdata_ff <= avs_writedata[SMRW_CMD_DATA_LSB +: 8];
                        ba_o     <= avs_writedata[SMRW_CMD_LOC_LSB +: 2];
                        addr_o   <= 18'h0_0000;
                        unique case (avs_writedata[SMRW_CMD_OP_LSB +: 3])
                            SMRW_OP_ENTER: begin
                                cmd_o    <= SMRW_DCMD_PRE;
                                cnt_ff   <= SMRW_TRP_CYC;
                                state_ff <= SMRW_PRE_WAIT;
                            end
                            SMRW_OP_READ: begin
                                cmd_o  <= SMRW_DCMD_RD;
                                addr_o[SMRW_A12] <=
                                    ctrl_ff[SMRW_CTRL_BL_LSB +: 2] == SMRW_BL_OTF;
                                cnt_ff   <= SMRW_RL_WAIT;
                                state_ff <= SMRW_RD_WAIT;
                            end
                            SMRW_OP_WRITE: begin
                                cmd_o  <= SMRW_DCMD_WR;
                                addr_o <= {10'h000, avs_writedata[SMRW_CMD_DATA_LSB +: 8]};
                                cnt_ff   <= SMRW_TWR_CYC;
                                state_ff <= SMRW_WR_WAIT;
                            end
                            SMRW_OP_EXIT: begin
                                cnt_ff   <= SMRW_TMPRR_CYC;
                                state_ff <= SMRW_EXIT_WAIT;
                            end
                            default: begin
                                busy_ff <= 1'b0;
                                done_ff <= 1'b1;
                            end
                        endcase
                    end
                end
                SMRW_PRE_WAIT: begin
                    if (cnt_ff <= 6'h1) begin
                        // MR3: enable, format, page
                        cmd_o  <= SMRW_DCMD_MRS;
                        ba_o   <= SMRW_MR3;
                        addr_o <= 18'h0_0000;
                        addr_o[SMRW_MR3_EN_BIT] <= 1'b1;
                        addr_o[SMRW_MR3_FMT_LSB +: 2] <= fmt;
                        addr_o[1:0] <= ctrl_ff[SMRW_CTRL_PAGE_LSB +: 2];
                        cnt_ff   <= SMRW_TMOD_CYC;
                        state_ff <= SMRW_MOD_WAIT;
                    end else begin
                        cnt_ff <= cnt_ff - 6'h1;
                    end
                end
                SMRW_EXIT_WAIT: begin
                    if (cnt_ff <= 6'h1) begin
                        cmd_o  <= SMRW_DCMD_MRS;
                        ba_o   <= SMRW_MR3;
                        addr_o <= 18'h0_0000;
                        cnt_ff   <= SMRW_TMOD_CYC;
                        mode_ff  <= 1'b0;
                        op_ff    <= SMRW_OP_EXIT;
                        state_ff <= SMRW_MOD_WAIT;
                    end else begin
                        cnt_ff <= cnt_ff - 6'h1;
                    end
                end
                SMRW_MOD_WAIT, SMRW_RD_WAIT, SMRW_WR_WAIT: begin
                    if (cnt_ff <= 6'h1) begin
                        if (state_ff == SMRW_MOD_WAIT)
                            mode_ff <= op_ff == SMRW_OP_ENTER;
                        busy_ff  <= 1'b0;
                        done_ff  <= 1'b1;
                        state_ff <= SMRW_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 6'h1;
                    end
                end
            endcase
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    sequence s_wr_issue;
        cmd_o == SMRW_DCMD_WR;
    endsequence

    property p_no_dbi;
        @(posedge core_clk) disable iff (!reset_n) s_wr_issue |-> !dbi_en_o;
    endproperty
    a_no_dbi: assert property (p_no_dbi) else $error("DBI on pattern write");

    property p_rd_col;
        @(posedge core_clk) disable iff (!reset_n)
            cmd_o == SMRW_DCMD_RD |-> addr_o[2:0] == 3'h0;
    endproperty
    a_rd_col: assert property (p_rd_col) else $error("read column not zero");

    property p_par_loc;
        @(posedge core_clk) disable iff (!reset_n)
            cmd_o == SMRW_DCMD_RD && fmt == SMRW_FMT_PARALLEL |-> ba_o == 2'h0;
    endproperty
    a_par_loc: assert property (p_par_loc) else $error("parallel read not location 0");

    property p_wr_page;
        @(posedge core_clk) disable iff (!reset_n)
            s_wr_issue |-> ctrl_ff[SMRW_CTRL_PAGE_LSB +: 2] == SMRW_PAGE0 && mode_ff;
    endproperty
    a_wr_page: assert property (p_wr_page) else $error("write outside page 0");

    property p_a12;
        @(posedge core_clk) disable iff (!reset_n)
            cmd_o == SMRW_DCMD_RD && ctrl_ff[SMRW_CTRL_BL_LSB +: 2] == SMRW_BL_OTF
            |-> addr_o[SMRW_A12];
    endproperty
    a_a12: assert property (p_a12) else $error("A12 low on chop read");

    property p_wr_recover;
        @(posedge core_clk) disable iff (!reset_n)
            s_wr_issue |=> (cmd_o == SMRW_DCMD_NOP)[*1] ##0 busy_ff;
    endproperty
    a_wr_recover: assert property (p_wr_recover) else $error("write recovery cut");

    property p_pre_gap;
        @(posedge core_clk) disable iff (!reset_n)
            cmd_o == SMRW_DCMD_PRE |=> cmd_o == SMRW_DCMD_NOP ##1 cmd_o == SMRW_DCMD_MRS;
    endproperty
    a_pre_gap: assert property (p_pre_gap) else $error("tRP not kept");

    property p_exit_mrs;
        @(posedge core_clk) disable iff (!reset_n)
            cmd_o == SMRW_DCMD_MRS && !addr_o[SMRW_MR3_EN_BIT] |-> !mode_ff ##1 !mode_ff;
    endproperty
    a_exit_mrs: assert property (p_exit_mrs) else $error("mode kept after exit");

    property p_wr_data;
        @(posedge core_clk) disable iff (!reset_n)
            s_wr_issue |-> addr_o[7:0] == wdata_ff && addr_o[17:8] == 10'h000;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not on A[7:0]");
endmodule : smrw_ctrl
`default_nettype wire

/* logic/smrw_pkg.sv */
// Package: constants for the pattern-register controller
`default_nettype none
package smrw_pkg;
    // ******************************************************************
    // Software register map (byte addresses, word index * 4)
    // ******************************************************************
    localparam logic [3:0] SMRW_OFF_CTRL   = 4'h0;
    localparam logic [3:0] SMRW_OFF_CMD    = 4'h4;
    localparam logic [3:0] SMRW_OFF_STATUS = 4'h8;
    localparam logic [3:0] SMRW_OFF_RDATA  = 4'hC;
    // CTRL fields
    localparam int SMRW_CTRL_FMT_LSB = 0;  // Readout format, 2 bits
    localparam int SMRW_CTRL_BL_LSB  = 2;  // MR0 burst-length field copy, 2 bits
    localparam int SMRW_CTRL_PAGE_LSB = 4; // Page select, 2 bits
    // CMD fields
    localparam int SMRW_CMD_LOC_LSB  = 0;  // Pattern location, 2 bits
    localparam int SMRW_CMD_OP_LSB   = 4;  // Operation, 3 bits
    localparam int SMRW_CMD_DATA_LSB = 8;  // Write data, 8 bits
    // Operation codes
    localparam logic [2:0] SMRW_OP_ENTER = 3'h1;
    localparam logic [2:0] SMRW_OP_READ  = 3'h2;
    localparam logic [2:0] SMRW_OP_WRITE = 3'h3;
    localparam logic [2:0] SMRW_OP_EXIT  = 3'h4;
    // Readout formats and burst-length field
    localparam logic [1:0] SMRW_FMT_SERIAL    = 2'h0;
    localparam logic [1:0] SMRW_FMT_PARALLEL  = 2'h1;
    localparam logic [1:0] SMRW_FMT_STAGGERED = 2'h2;
    localparam logic [1:0] SMRW_BL_OTF        = 2'h1;
    localparam logic [1:0] SMRW_PAGE0         = 2'h0;
    // Reset values
    localparam logic [5:0] SMRW_CTRL_RST = 6'h00;
    // ******************************************************************
    // Device command encoding on cmd_o
    // ******************************************************************
    localparam logic [2:0] SMRW_DCMD_NOP = 3'h0;
    localparam logic [2:0] SMRW_DCMD_MRS = 3'h1;
    localparam logic [2:0] SMRW_DCMD_RD  = 3'h2;
    localparam logic [2:0] SMRW_DCMD_WR  = 3'h3;
    localparam logic [2:0] SMRW_DCMD_PRE = 3'h4;
    localparam logic [1:0] SMRW_MR3      = 2'h3;
    localparam int SMRW_MR3_EN_BIT = 2;
    localparam int SMRW_MR3_FMT_LSB = 11;
    localparam int SMRW_A12 = 12;
    // ******************************************************************
    // Timing (ns) and cycle counts at 8 ns
    // ******************************************************************
    localparam int SMRW_CLK_NS   = 8;
    localparam int SMRW_TRP_NS   = 15;
    localparam int SMRW_TMOD_NS  = 24;
    localparam int SMRW_TWR_NS   = 16;
    localparam int SMRW_TMPRR_NS = 8;
    localparam int SMRW_RL_CYC   = 16;  // Read latency plus parity latency
    localparam logic [5:0] SMRW_TRP_CYC   = 6'((SMRW_TRP_NS + SMRW_CLK_NS - 1) / SMRW_CLK_NS);
    localparam logic [5:0] SMRW_TMOD_CYC  = 6'((SMRW_TMOD_NS + SMRW_CLK_NS - 1) / SMRW_CLK_NS);
    localparam logic [5:0] SMRW_TWR_CYC   = 6'((SMRW_TWR_NS + SMRW_CLK_NS - 1) / SMRW_CLK_NS);
    localparam logic [5:0] SMRW_TMPRR_CYC = 6'((SMRW_TMPRR_NS + SMRW_CLK_NS - 1) / SMRW_CLK_NS);
    // Read latency, eight beats and two synchroniser stages
    localparam logic [5:0] SMRW_RL_WAIT   = 6'(SMRW_RL_CYC + 10);
endpackage : smrw_pkg
`default_nettype wire

/* sim/smrw_dram_model.sv */
// Behavioural device-side model of the pattern registers
`timescale 1ns/10ps
`default_nettype none
module smrw_dram_model
    import smrw_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [2:0]  cmd,
    input  wire logic [1:0]  ba,
    input  wire logic [17:0] addr,
    input  wire logic        dbi_en,
    output logic      [7:0]  dq,
    output logic             dq_valid
);
    // ********
    // Device state
    // ********
    logic [7:0]  loc [4];
    logic        en;
    logic [1:0]  fmt;
    logic [17:0] last_addr;
    int          n_rd;
    int          n_pre;
    logic [2:0]  sr [SMRW_RL_CYC-1];
    logic [1:0]  cur;
    int          beat;
    logic [7:0]  junk;

    // Lane values for one UI of the burst
    // Four-lane parts take lanes 3:0; sixteen-lane parts repeat this byte on 15:8
    function automatic logic [7:0] lanes(input logic [1:0] n, input int b);
        logic [7:0] v;
        for (int j = 0; j < 8; j++) begin
            case (fmt)
                SMRW_FMT_PARALLEL:  v[j] = loc[n][7-j];
                SMRW_FMT_STAGGERED: v[j] = loc[2'(n+j)][b];
                default:            v[j] = loc[n][b];
            endcase
        end
        return v;
    endfunction : lanes

    // Mode register, pattern store and read bookkeeping
    always @(posedge core_clk) begin
        if (!reset_n) begin
            en <= 1'h0;
            n_rd <= 0;
            n_pre <= 0;
        end else begin
            if (cmd == SMRW_DCMD_PRE) n_pre <= n_pre + 1;
            if (cmd == SMRW_DCMD_MRS && ba == SMRW_MR3) begin
                en <= addr[SMRW_MR3_EN_BIT];
                fmt <= addr[12:11];
            end
            if (cmd == SMRW_DCMD_WR && en && !dbi_en) loc[ba] <= addr[7:0];
            if (cmd == SMRW_DCMD_RD && en) begin
                n_rd <= n_rd + 1;
                last_addr <= addr;
            end
        end
    end

    // Read latency line, parity latency included; a new read may follow at once
    always @(posedge core_clk) begin
        sr[0] <= {reset_n && en && cmd == SMRW_DCMD_RD, ba};
        for (int i = 1; i < SMRW_RL_CYC - 1; i++) sr[i] <= reset_n ? sr[i-1] : 3'h0;
    end

    // Burst of eight UIs in order 0 to 7, one per clock
    always @(posedge core_clk) begin
        junk <= ~dq;
        if (!reset_n) begin
            junk <= 8'h00;
            beat <= 8;
        end else if (sr[SMRW_RL_CYC-2][2]) begin
            cur <= sr[SMRW_RL_CYC-2][1:0];
            beat <= 0;
        end else if (beat < 8) begin
            beat <= beat + 1;
        end
    end

    // Released lines toggle so stale data never looks valid
    always_comb begin
        dq_valid = beat < 8;
        dq = dq_valid ? lanes(cur, beat) : junk;
    end
endmodule : smrw_dram_model
`default_nettype wire

/* sim/test_sdram_mpr_readout_and_write.sv */
// Testbench for the pattern-register controller
`timescale 1ns/10ps
`default_nettype none
module test_sdram_mpr_readout_and_write
    import smrw_pkg::*;
();
    logic        core_clk;
    logic        reset_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  cmd_o;
    logic [1:0]  ba_o;
    logic [17:0] addr_o;
    logic        dbi_en_o;
    logic [7:0]  dq_i;
    logic        dq_valid_i;
    int          n_errors;
    int          cmp_count;
    int          n0;
    logic [7:0]  pat [4];
    logic [31:0] rd;

    smrw_ctrl i_smrw_ctrl (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .cmd_o, .ba_o, .addr_o,
        .dbi_en_o, .dq_i, .dq_valid_i);
    smrw_dram_model i_smrw_dram_model (.core_clk, .reset_n, .cmd(cmd_o), .ba(ba_o),
        .addr(addr_o), .dbi_en(dbi_en_o), .dq(dq_i), .dq_valid(dq_valid_i));

    // ********
    // Reporting
    // ********
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // ********
    // Bus access: hold until waitrequest is sampled low
    // ********
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 100);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (n >= 100) begin
            n_errors++;
            end_sim();
        end
        @(posedge core_clk);
    endtask : bus

    // Issue one command and poll status until it is idle
    task automatic op(input logic [2:0] code, input logic [1:0] loc, input logic [7:0] d);
        int n;
        bus(1'h1, SMRW_OFF_CMD, {16'h0, d, 1'h0, code, 2'h0, loc});
        n = 0;
        do begin
            bus(1'h0, SMRW_OFF_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'h0 && n < 200);
        if (n >= 200) begin
            n_errors++;
            end_sim();
        end
    endtask : op

    task automatic enter(input logic [1:0] f, input logic [1:0] bl, input logic [1:0] pg);
        bus(1'h1, SMRW_OFF_CTRL, {26'h0, pg, bl, f});
        op(SMRW_OP_ENTER, 2'h0, 8'h00);
    endtask : enter

    // Read one location, then fetch the captured burst
    task automatic rloc(input logic [1:0] n);
        op(SMRW_OP_READ, n, 8'h00);
        bus(1'h0, SMRW_OFF_RDATA, 32'h0);
    endtask : rloc

    // Clock of 8 ns
    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end

    // ********
    // Main sequence
    // ********
    initial begin
        reset_n = 1'h0;
        avs_address = 4'h0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        n_errors = 0;
        cmp_count = 0;
        pat = '{8'h7F, 8'hA5, 8'h3C, 8'h81};
        repeat (16) @(posedge core_clk);
        reset_n <= 1'h1;
        @(posedge core_clk);
        bus(1'h0, SMRW_OFF_CTRL, 32'h0);
        check(rd, 32'(SMRW_CTRL_RST));
        bus(1'h0, 4'h2, 32'h0);
        check(rd, 32'h0);
        // Read outside pattern mode is refused
        op(SMRW_OP_READ, 2'h0, 8'h00);
        check(32'(rd[2]), 32'h1);
        check(32'(i_smrw_dram_model.n_rd), 32'h0);
        // Serial entry, four writes, four reads
        n0 = i_smrw_dram_model.n_pre;
        enter(SMRW_FMT_SERIAL, 2'h0, SMRW_PAGE0);
        check(32'(i_smrw_dram_model.n_pre - n0), 32'h1);
        check(32'(i_smrw_dram_model.en), 32'h1);
        for (int i = 0; i < 4; i++) begin
            op(SMRW_OP_WRITE, 2'(i), pat[i]);
            check(32'(dbi_en_o), 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            rloc(2'(i));
            check(32'(rd[7:0]), 32'(pat[i]));
            check(32'(i_smrw_dram_model.last_addr[2:0]), 32'h0);
        end
        op(SMRW_OP_EXIT, 2'h0, 8'h00);
        check(32'(rd[1]), 32'h0);
        check(32'(i_smrw_dram_model.en), 32'h0);
        // Staggered with burst length on the fly; values persist over exit
        enter(SMRW_FMT_STAGGERED, SMRW_BL_OTF, SMRW_PAGE0);
        for (int i = 3; i >= 0; i--) begin
            rloc(2'(i));
            check(32'(rd[7:0]), 32'(pat[i]));
            check(32'(i_smrw_dram_model.last_addr[SMRW_A12]), 32'h1);
        end
        op(SMRW_OP_EXIT, 2'h0, 8'h00);
        // Parallel: location 0 only, lane 0 carries bit 7
        enter(SMRW_FMT_PARALLEL, 2'h0, SMRW_PAGE0);
        rloc(2'h0);
        check(32'(rd[7:0]), 32'({8{pat[0][7]}}));
        check(32'(rd[15:8]), {24'h0, pat[0][0], pat[0][1], pat[0][2], pat[0][3],
                              pat[0][4], pat[0][5], pat[0][6], pat[0][7]});
        n0 = i_smrw_dram_model.n_rd;
        op(SMRW_OP_READ, 2'h1, 8'h00);
        check(32'(rd[2]), 32'h1);
        check(32'(i_smrw_dram_model.n_rd - n0), 32'h0);
        op(SMRW_OP_EXIT, 2'h0, 8'h00);
        // Writes with a page other than 0 are dropped
        enter(SMRW_FMT_SERIAL, 2'h0, 2'h1);
        op(SMRW_OP_WRITE, 2'h0, 8'h00);
        check(32'(rd[2]), 32'h1);
        check(32'(i_smrw_dram_model.loc[0]), 32'(pat[0]));
        op(SMRW_OP_EXIT, 2'h0, 8'h00);
        // Reserved readout format is refused
        enter(2'h3, 2'h0, SMRW_PAGE0);
        check(32'(rd[2]), 32'h1);
        check(32'(i_smrw_dram_model.en), 32'h0);
        end_sim();
    end
endmodule : test_sdram_mpr_readout_and_write
`default_nettype wire
